// >>> verilog/cosc_ctrl.sv
// Operation
// - drive field picks clock pin current 2, 4, 6 or 8 mA.
// - update timing 0 applies new rate immediately.
// - update timing 1 (the bit already stored, not the one written) defers new rate until leaving sleep.
// - rate 0 stops clock, pin held low.
// - rates 1..5 give 1..16 MHz from 16 MHz; 6, 7 reserved; rate 5 gives 8 MHz here, the same as rate 4.
// - oscillator mode 0x0 disables oscillator, no internal clock.
// - mode 0x4 uses external reference on crystal pin a.
// - mode 0xf enables internal crystal oscillator.
// - trim selects load capacitance in 0.3 pF steps, zero disconnects.
// - synthesizer on in synthesizer-on, receive and transmit states.
// - channel 11..26 tunes to 2405 + 5*(k-11) MHz.
// - synthesizer turn-on starts both calibrations automatically.
// - new channel value while running starts center-frequency calibration.
// - center-frequency calibration ends within 80 us with lock event.
// - delay-cell calibration completes after 6 us, no lock event.
// - unlock event on unexpected lock loss, lock event on lock.
// - lock event clears pending unlock, and vice versa.
// - lock on off-to-on, channel change, manual center calibration.
// - transmit-busy back to synthesizer-on may raise lock event.
// - manual start bits clear right after their write.
// - reset keeps running rate while rate field reads 1.
`timescale 1ns/100ps
`default_nettype none
`include "cosc_cfg.svh"

module cosc_ctrl (
    input  wire logic              clk_sys,
    input  wire logic              rst_n,
    input  wire logic [7:0]        reg_addr,
    input  wire logic [7:0]        reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic [7:0]             reg_rdata,
    input  wire logic              ref_clk_en,
    input  wire cosc_pkg::cosc_trx_t trx_state,
    input  wire logic              sleep_exit,
    input  wire logic              pll_lock_lost,
    output logic                   master_clock_out,
    output logic [1:0]             clock_out_drive_strength,
    output logic                   osc_enable,
    output logic                   osc_external,
    output logic                   ref_clock_gate,
    output logic [3:0]             oscillator_trim,
    output logic                   synth_enable,
    output logic [11:0]            synth_freq_mhz,
    output logic                   cf_cal_active,
    output logic                   dc_cal_active,
    output logic                   pll_lock_irq,
    output logic                   pll_unlock_irq
);

    // ------------------------------------------------------------
    // register bus decode
    // ------------------------------------------------------------
    cosc_pkg::cosc_bus_t bus;
    assign bus = '{wr: reg_wr, rd: reg_rd, addr: reg_addr, wdata: reg_wdata};

    wire wr_clkout = bus.wr && (bus.addr == `COSC_ADDR_CLKOUT);
    wire wr_chan   = bus.wr && (bus.addr == `COSC_ADDR_CHAN);
    wire wr_osc    = bus.wr && (bus.addr == `COSC_ADDR_OSC);
    wire wr_cfcal  = bus.wr && (bus.addr == `COSC_ADDR_CFCAL);
    wire wr_dccal  = bus.wr && (bus.addr == `COSC_ADDR_DCCAL);
    wire wr_ctrl   = bus.wr && (bus.addr == `COSC_ADDR_CTRL);

    logic [7:0] clkout_ff;
    logic [7:0] chan_ff;
    logic [7:0] osc_ff;
    logic [6:0] cfcal_ff;
    logic [6:0] dccal_ff;
    // power-up value only: reset leaves the live rate running
    logic [2:0] rate_live_ff = 3'h1;
    logic [2:0] rate_pend_ff;
    logic [2:0] rate_act_ff;
    logic       out_ff;
    logic [3:0] div_ff;
    logic [9:0] cf_cnt_ff;
    logic [9:0] dc_cnt_ff;
    logic       lock_ff;
    logic       unlock_ff;
    logic       synth_on_d_ff;
    cosc_pkg::cosc_trx_t trx_d_ff;

    // ------------------------------------------------------------
    // clock output rate selection
    // ------------------------------------------------------------
    wire [2:0] wr_rate   = bus.wdata[`COSC_RATE_HI:`COSC_RATE_LO];
    wire       sha_sel   = clkout_ff[`COSC_SHA_BIT];
    // reserved codes keep the previous rate rather than a random divider
    wire       rate_ok   = (wr_rate <= 3'h5);
    wire [2:0] nxt_rate_live =
        (wr_clkout && rate_ok && !sha_sel) ? wr_rate :
        (sleep_exit)                       ? rate_pend_ff :
                                             rate_live_ff;
    wire [2:0] nxt_rate_pend = (wr_clkout && rate_ok) ? wr_rate : rate_pend_ff;

    // divider half period in ref ticks: rate n gives 1 << (n-1) MHz, rate 5 stays at 8 MHz
    wire [3:0] half_lim =
        (rate_act_ff == 3'h1) ? 4'h7 :
        (rate_act_ff == 3'h2) ? 4'h3 :
        (rate_act_ff == 3'h3) ? 4'h1 : 4'h0;
    wire       div_wrap  = (div_ff >= half_lim);
    // new rate only at a low-phase boundary so no runt pulse escapes
    wire       boundary  = ref_clk_en && div_wrap && out_ff;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            clkout_ff    <= `COSC_RST_CLKOUT;
            rate_pend_ff <= 3'h1;
        end else begin
            if (wr_clkout) begin
                clkout_ff <= bus.wdata;
            end
            rate_pend_ff <= nxt_rate_pend;
        end
    end

    // live rate survives reset: output keeps running at the old rate
    always_ff @(posedge clk_sys) begin
        rate_live_ff <= nxt_rate_live;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rate_act_ff <= 3'h0;
            div_ff      <= 4'h0;
            out_ff      <= 1'b0;
        end else begin
            if (rate_act_ff == 3'h0 || rate_act_ff > 3'h5) begin
                out_ff      <= 1'b0;
                div_ff      <= 4'h0;
                rate_act_ff <= rate_live_ff;
            end else if (boundary || (ref_clk_en && div_wrap && !out_ff && rate_live_ff == 3'h0)) begin
                out_ff      <= 1'b0;
                div_ff      <= 4'h0;
                rate_act_ff <= rate_live_ff;
            end else if (ref_clk_en) begin
                div_ff <= div_wrap ? 4'h0 : div_ff + 4'h1;
                if (div_wrap) begin
                    out_ff <= ~out_ff;
                end
            end
        end
    end

    assign master_clock_out         = out_ff;
    assign clock_out_drive_strength = clkout_ff[`COSC_DRV_HI:`COSC_DRV_LO];

    // ------------------------------------------------------------
    // oscillator control
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            osc_ff <= `COSC_RST_OSC;
        end else if (wr_osc) begin
            osc_ff <= bus.wdata;
        end
    end

    wire [3:0] osc_mode = osc_ff[`COSC_MODE_HI:`COSC_MODE_LO];
    assign osc_enable      = (osc_mode == `COSC_MODE_XTAL);
    assign osc_external    = (osc_mode == `COSC_MODE_EXT);
    assign ref_clock_gate  = osc_enable || osc_external;
    assign oscillator_trim = osc_ff[`COSC_TRIM_HI:`COSC_TRIM_LO];

    // ------------------------------------------------------------
    // synthesizer channel and state
    // ------------------------------------------------------------
    wire [4:0] chan_k    = chan_ff[`COSC_CHAN_HI:`COSC_CHAN_LO];
    wire [4:0] wr_k      = bus.wdata[`COSC_CHAN_HI:`COSC_CHAN_LO];
    wire       k_ok      = (wr_k >= `COSC_CHAN_MIN) && (wr_k <= `COSC_CHAN_MAX);
    wire       synth_on  = (trx_state != cosc_pkg::COSC_TRANSCEIVER_OFF_STATE);
    wire       turn_on   = synth_on && !synth_on_d_ff;
    wire       chan_new  = wr_chan && k_ok && (wr_k != chan_k);
    wire       chan_cal  = chan_new && synth_on;
    wire       man_cf    = wr_cfcal && bus.wdata[`COSC_START_BIT];
    wire       man_dc    = wr_dccal && bus.wdata[`COSC_START_BIT];
    wire       tx_back   = (trx_d_ff == cosc_pkg::COSC_TX_BUSY) &&
                           (trx_state == cosc_pkg::COSC_SYNTH_ON);
    wire [11:0] k_off    = {7'h00, chan_k} - {7'h00, `COSC_CHAN_MIN};

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            chan_ff       <= `COSC_RST_CHAN;
            synth_on_d_ff <= 1'b0;
            trx_d_ff      <= cosc_pkg::COSC_TRANSCEIVER_OFF_STATE;
            cfcal_ff      <= 7'(`COSC_RST_CFCAL);
            dccal_ff      <= 7'(`COSC_RST_DCCAL);
        end else begin
            if (wr_chan) begin
                chan_ff <= {bus.wdata[7:5], k_ok ? wr_k : chan_k};
            end
            if (wr_cfcal) begin
                cfcal_ff <= bus.wdata[6:0];
            end
            if (wr_dccal) begin
                dccal_ff <= bus.wdata[6:0];
            end
            synth_on_d_ff <= synth_on;
            trx_d_ff      <= trx_state;
        end
    end

    assign synth_enable   = synth_on;
    assign synth_freq_mhz = `COSC_FREQ_BASE + `COSC_FREQ_STEP * k_off;

    // ------------------------------------------------------------
    // calibration sequencing
    // ------------------------------------------------------------
    wire cf_start = synth_on && (turn_on || chan_cal || man_cf);
    wire dc_start = synth_on && (turn_on || man_dc);
    wire cf_done  = (cf_cnt_ff == 10'h001);
    wire dc_done  = (dc_cnt_ff == 10'h001);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cf_cnt_ff <= 10'h000;
            dc_cnt_ff <= 10'h000;
        end else begin
            if (!synth_on) begin
                cf_cnt_ff <= 10'h000;
            end else if (cf_start) begin
                cf_cnt_ff <= 10'(`COSC_CF_CYC);
            end else if (cf_cnt_ff != 10'h000) begin
                cf_cnt_ff <= cf_cnt_ff - 10'h001;
            end
            if (!synth_on) begin
                dc_cnt_ff <= 10'h000;
            end else if (dc_start) begin
                dc_cnt_ff <= 10'(`COSC_DC_CYC);
            end else if (dc_cnt_ff != 10'h000) begin
                dc_cnt_ff <= dc_cnt_ff - 10'h001;
            end
        end
    end

    assign cf_cal_active = (cf_cnt_ff != 10'h000);
    assign dc_cal_active = (dc_cnt_ff != 10'h000);

    // ------------------------------------------------------------
    // lock and unlock events
    // ------------------------------------------------------------
    cosc_pkg::cosc_cal_t cal;
    assign cal.lock_evt   = synth_on && ((cf_done && !cf_start) || tx_back);
    assign cal.unlock_evt = synth_on && pll_lock_lost && !cal.lock_evt;
    assign cal.cf_busy    = cf_cal_active;
    assign cal.dc_busy    = dc_cal_active;

    // clear via control register; a same-cycle event wins over the clear
    wire clr_lock   = wr_ctrl && bus.wdata[0];
    wire clr_unlock = wr_ctrl && bus.wdata[1];

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            lock_ff   <= 1'b0;
            unlock_ff <= 1'b0;
        end else begin
            if (cal.lock_evt) begin
                lock_ff   <= 1'b1;
                unlock_ff <= 1'b0;
            end else if (cal.unlock_evt) begin
                unlock_ff <= 1'b1;
                lock_ff   <= 1'b0;
            end else begin
                if (clr_lock) lock_ff <= 1'b0;
                if (clr_unlock) unlock_ff <= 1'b0;
            end
        end
    end

    assign pll_lock_irq   = lock_ff;
    assign pll_unlock_irq = unlock_ff;

    // ------------------------------------------------------------
    // read data, one cycle after the strobe
    // ------------------------------------------------------------
    wire [7:0] rd_mux =
        (bus.addr == `COSC_ADDR_CLKOUT) ? clkout_ff :
        (bus.addr == `COSC_ADDR_CHAN)   ? chan_ff :
        (bus.addr == `COSC_ADDR_OSC)    ? osc_ff :
        (bus.addr == `COSC_ADDR_CFCAL)  ? {1'b0, cfcal_ff} :
        (bus.addr == `COSC_ADDR_DCCAL)  ? {1'b0, dccal_ff} :
        (bus.addr == `COSC_ADDR_STATUS) ? {2'h0, cal.cf_busy, cal.dc_busy,
                                           1'b0, rate_act_ff[0], unlock_ff, lock_ff} :
                                          8'h00;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= bus.rd ? rd_mux : 8'h00;
        end
    end

endmodule : cosc_ctrl
`default_nettype wire

// >>> verilog/cosc_cfg.svh
`ifndef COSC_CFG_SVH
`define COSC_CFG_SVH

// register offsets
`define COSC_ADDR_CLKOUT     8'h03
`define COSC_ADDR_CHAN       8'h08
`define COSC_ADDR_OSC        8'h12
`define COSC_ADDR_CFCAL      8'h1a
`define COSC_ADDR_DCCAL      8'h1b
`define COSC_ADDR_STATUS     8'h20
`define COSC_ADDR_CTRL       8'h21

// reset values
`define COSC_RST_CLKOUT      8'h19
`define COSC_RST_CHAN        8'h2b
`define COSC_RST_OSC         8'hf0
`define COSC_RST_CFCAL       8'h57
`define COSC_RST_DCCAL       8'h20

// field positions
`define COSC_DRV_HI          5
`define COSC_DRV_LO          4
`define COSC_SHA_BIT         3
`define COSC_RATE_HI         2
`define COSC_RATE_LO         0
`define COSC_MODE_HI         7
`define COSC_MODE_LO         4
`define COSC_TRIM_HI         3
`define COSC_TRIM_LO         0
`define COSC_CHAN_HI         4
`define COSC_CHAN_LO         0
`define COSC_START_BIT       7

// oscillator modes and channel limits
`define COSC_MODE_OFF        4'h0
`define COSC_MODE_EXT        4'h4
`define COSC_MODE_XTAL       4'hf
`define COSC_CHAN_MIN        5'h0b
`define COSC_CHAN_MAX        5'h1a
`define COSC_FREQ_BASE       12'h965
`define COSC_FREQ_STEP       12'h005

// calibration timing at 10 MHz
`define COSC_CLK_MHZ         10
`define COSC_CF_CAL_US       80
`define COSC_DC_CAL_US       6
`define COSC_CF_CYC          (`COSC_CF_CAL_US * `COSC_CLK_MHZ)
`define COSC_DC_CYC          (`COSC_DC_CAL_US * `COSC_CLK_MHZ)

`endif

// >>> verilog/cosc_pkg.sv
package cosc_pkg;

    typedef enum logic [1:0] {
        COSC_TRANSCEIVER_OFF_STATE,
        COSC_SYNTH_ON,
        COSC_RX_ON,
        COSC_TX_BUSY
    } cosc_trx_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } cosc_bus_t;

    typedef struct packed {
        logic       lock_evt;
        logic       unlock_evt;
        logic       cf_busy;
        logic       dc_busy;
    } cosc_cal_t;

endpackage : cosc_pkg

// >>> tb/cosc_monitor.sv
`timescale 1ns/100ps
`default_nettype none
`include "cosc_cfg.svh"

module cosc_monitor (
    input wire logic                clk_sys,
    input wire logic                rst_n,
    input wire logic [7:0]          reg_addr,
    input wire logic [7:0]          reg_wdata,
    input wire logic                reg_wr,
    input wire logic                reg_rd,
    input wire logic [7:0]          reg_rdata,
    input wire cosc_pkg::cosc_trx_t trx_state,
    input wire logic                pll_lock_lost,
    input wire logic                master_clock_out,
    input wire logic [1:0]          clock_out_drive_strength,
    input wire logic                osc_enable,
    input wire logic                osc_external,
    input wire logic                ref_clock_gate,
    input wire logic [3:0]          oscillator_trim,
    input wire logic                synth_enable,
    input wire logic [11:0]         synth_freq_mhz,
    input wire logic                cf_cal_active,
    input wire logic                dc_cal_active,
    input wire logic                pll_lock_irq,
    input wire logic                pll_unlock_irq
);
    // ----------------------------------------
    // run-length counters and write decodes
    // ----------------------------------------
    logic [15:0]      cf_cnt_ff;
    logic [15:0]      dc_cnt_ff;
    logic             sha_ff;
    cosc_pkg::cosc_trx_t trx_prev_ff;
    wire logic [11:0] wr_freq = `COSC_FREQ_BASE + `COSC_FREQ_STEP * (12'(reg_wdata[4:0]) - 12'h00b);
    wire logic        chan_ok = reg_wdata[4:0] >= `COSC_CHAN_MIN && reg_wdata[4:0] <= `COSC_CHAN_MAX;
    wire logic        wr_clk  = reg_wr && reg_addr == `COSC_ADDR_CLKOUT;
    wire logic        wr_osc  = reg_wr && reg_addr == `COSC_ADDR_OSC;
    wire logic        wr_chan = reg_wr && reg_addr == `COSC_ADDR_CHAN && chan_ok;
    wire logic        on_now  = synth_enable && trx_state == trx_prev_ff;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cf_cnt_ff   <= 16'h0000;
            dc_cnt_ff   <= 16'h0000;
            sha_ff      <= 1'b1;
            trx_prev_ff <= cosc_pkg::COSC_TRANSCEIVER_OFF_STATE;
        end else begin
            trx_prev_ff <= trx_state;
            if (wr_clk) sha_ff <= reg_wdata[`COSC_SHA_BIT];
            cf_cnt_ff <= cf_cal_active ? cf_cnt_ff + 16'h0001 : 16'h0000;
            dc_cnt_ff <= dc_cal_active ? dc_cnt_ff + 16'h0001 : 16'h0000;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    drive_field_a : assert property (
        wr_clk |=> clock_out_drive_strength == $past(reg_wdata[5:4])) else $error("drive field not applied");
    clk_stop_a : assert property (
        wr_clk && reg_wdata[2:0] == 3'h0 && !sha_ff |-> ##[1:18] (!master_clock_out)[*8])
        else $error("clock not stopped");
    osc_mode_a : assert property (
        wr_osc |=> osc_enable == ($past(reg_wdata[7:4]) == 4'hf) && osc_external == ($past(reg_wdata[7:4]) == 4'h4)
        && ref_clock_gate == (osc_enable || osc_external)) else $error("oscillator mode decode wrong");
    trim_field_a : assert property (
        wr_osc |=> oscillator_trim == $past(reg_wdata[3:0])) else $error("trim not applied");
    synth_state_a : assert property (
        synth_enable == (trx_state != cosc_pkg::COSC_TRANSCEIVER_OFF_STATE)) else $error("synth enable wrong");
    chan_freq_a : assert property (
        wr_chan |=> synth_freq_mhz == $past(wr_freq)) else $error("channel frequency wrong");
    turn_on_cal_a : assert property (
        $past(trx_state) == cosc_pkg::COSC_TRANSCEIVER_OFF_STATE && synth_enable |-> ##[0:2] (cf_cal_active && dc_cal_active))
        else $error("turn-on calibration missing");
    chan_recal_a : assert property (
        on_now && wr_chan && wr_freq != synth_freq_mhz |-> ##[1:2] cf_cal_active) else $error("no recalibration");
    cf_bound_a : assert property (
        cf_cnt_ff <= `COSC_CF_CYC) else $error("center calibration too long");
    cf_lock_a : assert property (
        $fell(cf_cal_active) && synth_enable && $past(synth_enable) |-> ##[0:2] pll_lock_irq)
        else $error("no lock after calibration");
    dc_length_a : assert property (
        $fell(dc_cal_active) && synth_enable && $past(synth_enable) |-> dc_cnt_ff == `COSC_DC_CYC)
        else $error("delay calibration length wrong");
    unlock_evt_a : assert property (
        synth_enable && pll_lock_lost |=> pll_unlock_irq && !pll_lock_irq) else $error("unlock not raised");
    irq_excl_a : assert property (
        !(pll_lock_irq && pll_unlock_irq)) else $error("lock and unlock both pending");
    start_clear_a : assert property (
        reg_rd && (reg_addr == `COSC_ADDR_CFCAL || reg_addr == `COSC_ADDR_DCCAL) |=> !reg_rdata[7])
        else $error("start bit reads set");

    turn_on_c : cover property ($rose(synth_enable));
    unlock_c : cover property ($rose(pll_unlock_irq));
    recal_c : cover property (on_now && wr_chan ##1 cf_cal_active);
endmodule : cosc_monitor

bind cosc_ctrl cosc_monitor u_mon (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .trx_state(trx_state), .pll_lock_lost(pll_lock_lost),
    .master_clock_out(master_clock_out), .clock_out_drive_strength(clock_out_drive_strength),
    .osc_enable(osc_enable), .osc_external(osc_external), .ref_clock_gate(ref_clock_gate),
    .oscillator_trim(oscillator_trim), .synth_enable(synth_enable), .synth_freq_mhz(synth_freq_mhz),
    .cf_cal_active(cf_cal_active), .dc_cal_active(dc_cal_active), .pll_lock_irq(pll_lock_irq),
    .pll_unlock_irq(pll_unlock_irq));

`default_nettype wire

// >>> tb/cosc_host_model.sv
`timescale 1ns/100ps
`default_nettype none

module cosc_host_model (
    input  wire logic  clk_sys,
    input  wire logic  master_clock_out,
    output logic [7:0] last_half,
    output logic [15:0] edge_cnt
);
    // no reset: the host keeps running while the device resets
    logic [7:0] run_ff  = 8'h00;
    logic       prev_ff = 1'b0;
    logic [7:0] half_ff = 8'h00;
    logic [15:0] edges_ff = 16'h0000;

    always_ff @(posedge clk_sys) begin
        prev_ff <= master_clock_out;
        run_ff  <= (master_clock_out != prev_ff) ? 8'h01 : run_ff + 8'h01;
        if (master_clock_out != prev_ff) begin
            half_ff  <= run_ff;
            edges_ff <= edges_ff + 16'h0001;
        end
    end

    assign last_half = half_ff;
    assign edge_cnt  = edges_ff;
endmodule : cosc_host_model

`default_nettype wire

// >>> tb/cosc_ctrl_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "cosc_cfg.svh"
`define COSC_CHK(g, e) begin n_checks++; if ((g) !== (e)) begin fails++; $display("Error t=%0t got %h exp %h", $time, g, e); end end

module cosc_ctrl_tb;
    logic                clk_sys = 1'b0;
    logic                rst_n = 1'b0;
    cosc_pkg::cosc_bus_t bus = '0;
    cosc_pkg::cosc_trx_t trx = cosc_pkg::COSC_TRANSCEIVER_OFF_STATE;
    logic                sleep_exit = 1'b0;
    logic                lock_lost = 1'b0;
    logic [7:0]          rdata, last_half, rd_val;
    logic [15:0]         edge_cnt, edge_was;
    logic [11:0]         freq;
    logic [3:0]          trim;
    logic [1:0]          drv;
    logic                mco, osc_en, osc_ext, gate, syn_en, cf_act, dc_act, lock, unlock;
    logic [7:0]          halfs [1:5] = '{8'h08, 8'h04, 8'h02, 8'h01, 8'h01};
    logic [7:0]          ra [6] = '{8'h03, 8'h08, 8'h12, 8'h1a, 8'h1b, 8'h40};
    logic [7:0]          rv [6] = '{8'h19, 8'h2b, 8'hf0, 8'h57, 8'h20, 8'h00};
    logic [3:0]          modes [3] = '{4'h0, 4'h4, 4'hf};
    int                  fails = 0;
    int                  n_checks = 0;

    initial forever #50 clk_sys = ~clk_sys;

    cosc_ctrl u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(bus.addr), .reg_wdata(bus.wdata), .reg_wr(bus.wr),
        .reg_rd(bus.rd), .reg_rdata(rdata), .ref_clk_en(1'b1), .trx_state(trx), .sleep_exit(sleep_exit),
        .pll_lock_lost(lock_lost), .master_clock_out(mco), .clock_out_drive_strength(drv), .osc_enable(osc_en),
        .osc_external(osc_ext), .ref_clock_gate(gate), .oscillator_trim(trim), .synth_enable(syn_en),
        .synth_freq_mhz(freq), .cf_cal_active(cf_act), .dc_cal_active(dc_act), .pll_lock_irq(lock),
        .pll_unlock_irq(unlock));
    cosc_host_model u_host (.clk_sys(clk_sys), .master_clock_out(mco), .last_half(last_half), .edge_cnt(edge_cnt));

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : tick

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk_sys);
        bus.wr <= 1'b0;
        #1;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        @(posedge clk_sys);
        bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk_sys);
        bus.rd <= 1'b0;
        #1 rd_val = rdata;
    endtask : rd

    task automatic half_chk(input logic [7:0] e);
        tick(40);
        `COSC_CHK(last_half, e)
    endtask : half_chk

    task automatic pulse_sleep;
        @(posedge clk_sys);
        sleep_exit <= 1'b1;
        @(posedge clk_sys);
        sleep_exit <= 1'b0;
    endtask : pulse_sleep

    task automatic wait_cf;
        int i;
        for (i = 0; i < 1000 && cf_act !== 1'b0; i++) @(posedge clk_sys);
        if (i == 1000) begin
            fails++;
            tally_and_finish();
        end
        tick(3);
    endtask : wait_cf

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : tally_and_finish

    initial begin
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            rd(ra[i]);
            `COSC_CHK(rd_val, rv[i])
        end
        for (int d = 0; d < 4; d++) begin
            wr(`COSC_ADDR_CLKOUT, {2'b00, 2'(d), 4'h1});
            `COSC_CHK(drv, 2'(d))
        end
        for (int n = 1; n < 6; n++) begin
            wr(`COSC_ADDR_CLKOUT, 8'(n));
            half_chk(halfs[n]);
        end
        wr(`COSC_ADDR_CLKOUT, 8'h06);
        half_chk(8'h01);
        wr(`COSC_ADDR_CLKOUT, 8'h0d);
        wr(`COSC_ADDR_CLKOUT, 8'h09);
        half_chk(8'h01);
        pulse_sleep();
        half_chk(8'h08);
        wr(`COSC_ADDR_CLKOUT, 8'h00);
        wr(`COSC_ADDR_CLKOUT, 8'h00);
        tick(20);
        edge_was = edge_cnt;
        tick(30);
        `COSC_CHK({mco, edge_cnt}, {1'b0, edge_was})
        wr(`COSC_ADDR_CLKOUT, 8'h05);
        @(posedge clk_sys);
        rst_n <= 1'b0;
        @(posedge clk_sys);
        rst_n <= 1'b1;
        rd(`COSC_ADDR_CLKOUT);
        `COSC_CHK(rd_val, 8'h19)
        half_chk(8'h01);
        pulse_sleep();
        half_chk(8'h08);
        for (int m = 0; m < 3; m++) begin
            wr(`COSC_ADDR_OSC, {modes[m], 4'(m * 7)});
            `COSC_CHK({osc_en, osc_ext, gate}, {modes[m] == 4'hf, modes[m] == 4'h4, modes[m] != 4'h0})
            `COSC_CHK(trim, 4'(m * 7))
        end
        for (int k = 11; k < 27; k++) begin
            wr(`COSC_ADDR_CHAN, {3'b001, 5'(k)});
            `COSC_CHK(freq, 12'(2405 + 5 * (k - 11)))
        end
        wr(`COSC_ADDR_CHAN, 8'h25);
        `COSC_CHK(freq, 12'h9b0)
        @(posedge clk_sys);
        trx <= cosc_pkg::COSC_SYNTH_ON;
        tick(3);
        `COSC_CHK({syn_en, cf_act, dc_act}, 3'b111)
        wait_cf();
        `COSC_CHK({lock, unlock}, 2'b10)
        @(posedge clk_sys);
        lock_lost <= 1'b1;
        @(posedge clk_sys);
        lock_lost <= 1'b0;
        #1 `COSC_CHK({lock, unlock}, 2'b01)
        wr(`COSC_ADDR_CHAN, 8'h2c);
        tick(2);
        `COSC_CHK(cf_act, 1'b1)
        wait_cf();
        `COSC_CHK({lock, unlock}, 2'b10)
        wr(`COSC_ADDR_CTRL, 8'h01);
        `COSC_CHK(lock, 1'b0)
        wr(`COSC_ADDR_CFCAL, 8'h80);
        rd(`COSC_ADDR_CFCAL);
        `COSC_CHK({rd_val[7], cf_act}, 2'b01)
        wait_cf();
        `COSC_CHK(lock, 1'b1)
        wr(`COSC_ADDR_CTRL, 8'h01);
        wr(`COSC_ADDR_DCCAL, 8'h80);
        tick(2);
        `COSC_CHK({dc_act, cf_act}, 2'b10)
        tick(70);
        `COSC_CHK({dc_act, lock}, 2'b00)
        @(posedge clk_sys);
        trx <= cosc_pkg::COSC_TX_BUSY;
        repeat (3) @(posedge clk_sys);
        trx <= cosc_pkg::COSC_SYNTH_ON;
        tick(3);
        `COSC_CHK(lock, 1'b1)
        tally_and_finish();
    end
endmodule : cosc_ctrl_tb

`default_nettype wire
